// ---- diag_monitor_defs.svh ----
`ifndef DIAG_MONITOR_DEFS_SVH
`define DIAG_MONITOR_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DIAG_ENABLE_CTRL_OFS       8'h53
`define SENSE_FILTER_FAULT_CFG_OFS 8'h54
`define BATTERY_RESULT_HIGH_OFS    8'h56
`define BATTERY_RESULT_LOW_TAG_OFS 8'h57
`define BIAS_RESULT_HIGH_OFS       8'h58
`define BIAS_RESULT_LOW_TAG_OFS    8'h59
`define INPUT1_POS_RESULT_HIGH_OFS 8'h5A

// ----------------------------------------------------------------
// sense_filter_fault_cfg fields
// ----------------------------------------------------------------
`define ANALOG_FILT_MSB            6
`define ANALOG_FILT_LSB            5
`define BATTERY_FILT_MSB           3
`define BATTERY_FILT_LSB           2
`define SHORT_MERGE_BIT            0
`define FILT_CFG_WRITE_MASK        8'h6D
`define FILT_CFG_RESET             8'h48
`define FILTER_CHOICE_RESET        2'h2
`define SHORT_MERGE_RESET          1'h0

// ----------------------------------------------------------------
// diag_enable_ctrl fields
// ----------------------------------------------------------------
`define FORCE_EN_BIT               7
`define EN_BIAS_LOAD_BIT           6
`define EN_BIAS_BIT                5
`define EN_BATTERY_BIT             4
`define EN_TEMP_BIT                3
`define EN_CTRL_WRITE_MASK         8'hFE
`define EN_CTRL_RESET              8'h00

// ----------------------------------------------------------------
// result layout and channel tags
// ----------------------------------------------------------------
`define RESULT_RESET               12'h000
`define RESULT_UPPER_MSB           11
`define RESULT_UPPER_LSB           4
`define RESULT_LOWER_MSB           3
`define RESULT_LOWER_LSB           0
`define TAG_BATTERY                4'h0
`define TAG_BIAS                   4'h1
`define TAG_INPUT1_POS             4'h2
`define READ_IDLE_VALUE            8'h00

`endif

// ---- diag_monitor_pkg.sv ----
package diag_monitor_pkg;

    typedef logic [7:0]  reg_byte_t;
    typedef logic [11:0] sar_result_t;
    typedef logic [3:0]  chan_tag_t;

    // sense path filter corner
    typedef enum logic [1:0] {
        FILT_3M5HZ  = 2'h0,
        FILT_200KHZ = 2'h1,
        FILT_100KHZ = 2'h2,
        FILT_BYPASS = 2'h3
    } filter_choice_t;

endpackage : diag_monitor_pkg

// ---- result_slot_if.sv ----
`timescale 1ns/1ps
interface result_slot_if;
    logic                      load;
    diag_monitor_pkg::sar_result_t data;
    logic [7:0]                upper;
    logic [3:0]                lower;

    modport producer (output load, output data, input upper, input lower);
    modport slot     (input load, input data, output upper, output lower);
endinterface : result_slot_if

// ---- diag_result_slot.sv ----
`timescale 1ns/1ps
`include "diag_monitor_defs.svh"

module diag_result_slot
    import diag_monitor_pkg::*;
(
    input  wire logic   core_clk_i,
    input  wire logic   sys_rst_i,
    result_slot_if.slot port
);

    sar_result_t result_q;

    // ----------------------------------------------------------------
    // result storage
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            result_q <= `RESULT_RESET;
        end else if (port.load) begin
            result_q <= port.data;
        end
    end

    assign port.upper = result_q[`RESULT_UPPER_MSB:`RESULT_UPPER_LSB];
    assign port.lower = result_q[`RESULT_LOWER_MSB:`RESULT_LOWER_LSB];

endmodule : diag_result_slot

// ---- diag_monitor_registers.sv ----
`timescale 1ns/1ps
`include "diag_monitor_defs.svh"

// Operation
// - two 2-bit filter fields: 3.5MHz, 200kHz, 100kHz, bypass; both reset to 100kHz
// - merge bit 0 reports input overvoltage and short-to-battery separately; resets 0
// - merge bit 1 ORs both conditions into one battery-short fault
// - reserved config bits read zero; software writes only zero there
// - battery, bias, input1 positive upper result bytes, read-only, reset zero
// - low result registers: nibble in 7..4, fixed tag in 3..0 (battery 0, bias 1)
// - force 0: any input diagnostic auto-enables battery, bias, load, temperature
module diag_monitor_registers
    import diag_monitor_pkg::*;
(
    input  wire logic           core_clk_i,
    input  wire logic           sys_rst_i,
    // register port
    input  wire logic [7:0]     reg_addr_i,
    input  wire logic [7:0]     reg_wdata_i,
    input  wire logic           reg_wr_i,
    input  wire logic           reg_rd_i,
    output logic [7:0]          reg_rdata_o,
    output logic                reg_rvalid_o,
    // converter results
    input  wire logic           sar_valid_i,
    input  wire logic [3:0]     sar_channel_i,
    input  wire logic [11:0]    sar_data_i,
    // fault conditions
    input  wire logic           input_overvoltage_i,
    input  wire logic           input_short_battery_i,
    input  wire logic           input_diag_any_i,
    output logic                overvoltage_fault_o,
    output logic                battery_short_fault_o,
    // sense path settings
    output filter_choice_t      analog_supply_filter_choice_o,
    output filter_choice_t      battery_filter_choice_o,
    // diagnostic enables
    output logic                battery_diag_en_o,
    output logic                bias_diag_en_o,
    output logic                bias_load_diag_en_o,
    output logic                temp_diag_en_o
);

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    logic filt_cfg_wr;
    logic en_ctrl_wr;

    assign filt_cfg_wr = reg_wr_i && (reg_addr_i == `SENSE_FILTER_FAULT_CFG_OFS);
    assign en_ctrl_wr  = reg_wr_i && (reg_addr_i == `DIAG_ENABLE_CTRL_OFS);

    // ----------------------------------------------------------------
    // configuration storage
    // ----------------------------------------------------------------
    filter_choice_t analog_supply_filter_choice_q;
    filter_choice_t battery_filter_choice_q;
    logic           battery_short_merge_q;
    reg_byte_t      enable_ctrl_q;
    reg_byte_t      filt_wdata;
    reg_byte_t      en_wdata;

    assign filt_wdata = reg_wdata_i & `FILT_CFG_WRITE_MASK;
    assign en_wdata   = reg_wdata_i & `EN_CTRL_WRITE_MASK;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            analog_supply_filter_choice_q <= filter_choice_t'(`FILTER_CHOICE_RESET);
            battery_filter_choice_q       <= filter_choice_t'(`FILTER_CHOICE_RESET);
            battery_short_merge_q         <= `SHORT_MERGE_RESET;
        end else if (filt_cfg_wr) begin
            analog_supply_filter_choice_q <=
                filter_choice_t'(filt_wdata[`ANALOG_FILT_MSB:`ANALOG_FILT_LSB]);
            battery_filter_choice_q <=
                filter_choice_t'(filt_wdata[`BATTERY_FILT_MSB:`BATTERY_FILT_LSB]);
            battery_short_merge_q <= filt_wdata[`SHORT_MERGE_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            enable_ctrl_q <= `EN_CTRL_RESET;
        end else if (en_ctrl_wr) begin
            enable_ctrl_q <= en_wdata;
        end
    end

    assign analog_supply_filter_choice_o = analog_supply_filter_choice_q;
    assign battery_filter_choice_o       = battery_filter_choice_q;

    // ----------------------------------------------------------------
    // fault sources
    // ----------------------------------------------------------------
    logic merged_short;

    assign merged_short = input_overvoltage_i | input_short_battery_i;

    // ----------------------------------------------------------------
    // fault reporting
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            overvoltage_fault_o   <= 1'b0;
            battery_short_fault_o <= 1'b0;
        end else if (battery_short_merge_q) begin
            overvoltage_fault_o   <= 1'b0;
            battery_short_fault_o <= merged_short;
        end else begin
            overvoltage_fault_o   <= input_overvoltage_i;
            battery_short_fault_o <= input_short_battery_i;
        end
    end

    // ----------------------------------------------------------------
    // diagnostic enables
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            battery_diag_en_o   <= 1'b0;
            bias_diag_en_o      <= 1'b0;
            bias_load_diag_en_o <= 1'b0;
            temp_diag_en_o      <= 1'b0;
        end else if (enable_ctrl_q[`FORCE_EN_BIT]) begin
            battery_diag_en_o   <= enable_ctrl_q[`EN_BATTERY_BIT];
            bias_diag_en_o      <= enable_ctrl_q[`EN_BIAS_BIT];
            bias_load_diag_en_o <= enable_ctrl_q[`EN_BIAS_LOAD_BIT];
            temp_diag_en_o      <= enable_ctrl_q[`EN_TEMP_BIT];
        end else begin
            battery_diag_en_o   <= input_diag_any_i;
            bias_diag_en_o      <= input_diag_any_i;
            bias_load_diag_en_o <= input_diag_any_i;
            temp_diag_en_o      <= input_diag_any_i;
        end
    end

    // ----------------------------------------------------------------
    // converter result slots
    // ----------------------------------------------------------------
    result_slot_if battery_slot ();
    result_slot_if bias_slot ();
    result_slot_if input1_pos_slot ();

    assign battery_slot.load    = sar_valid_i && sar_channel_i == `TAG_BATTERY;
    assign battery_slot.data    = sar_data_i;
    assign bias_slot.load       = sar_valid_i && sar_channel_i == `TAG_BIAS;
    assign bias_slot.data       = sar_data_i;
    assign input1_pos_slot.load = sar_valid_i && sar_channel_i == `TAG_INPUT1_POS;
    assign input1_pos_slot.data = sar_data_i;

    diag_result_slot u_battery_slot (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .port       (battery_slot)
    );

    diag_result_slot u_bias_slot (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .port       (bias_slot)
    );

    diag_result_slot u_input1_pos_slot (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .port       (input1_pos_slot)
    );

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    reg_byte_t read_mux;

    always_comb begin
        read_mux = `READ_IDLE_VALUE;
        case (reg_addr_i)
            `SENSE_FILTER_FAULT_CFG_OFS: begin
                read_mux                                       = 8'h00;
                read_mux[`ANALOG_FILT_MSB:`ANALOG_FILT_LSB]    = analog_supply_filter_choice_q;
                read_mux[`BATTERY_FILT_MSB:`BATTERY_FILT_LSB]  = battery_filter_choice_q;
                read_mux[`SHORT_MERGE_BIT]                     = battery_short_merge_q;
            end
            `DIAG_ENABLE_CTRL_OFS: begin
                read_mux = enable_ctrl_q;
            end
            `BATTERY_RESULT_HIGH_OFS: begin
                read_mux = battery_slot.upper;
            end
            `BATTERY_RESULT_LOW_TAG_OFS: begin
                read_mux = {battery_slot.lower, `TAG_BATTERY};
            end
            `BIAS_RESULT_HIGH_OFS: begin
                read_mux = bias_slot.upper;
            end
            `BIAS_RESULT_LOW_TAG_OFS: begin
                read_mux = {bias_slot.lower, `TAG_BIAS};
            end
            `INPUT1_POS_RESULT_HIGH_OFS: begin
                read_mux = input1_pos_slot.upper;
            end
            default: begin
                read_mux = `READ_IDLE_VALUE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= `READ_IDLE_VALUE;
        end else if (reg_rd_i) begin
            reg_rdata_o <= read_mux;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
        end
    end

endmodule : diag_monitor_registers

// ---- diag_monitor_registers_properties.sv ----
`timescale 1ns/1ps
`include "diag_monitor_defs.svh"
module diag_monitor_checker
    import diag_monitor_pkg::*;
(
    input wire logic           core_clk_i,
    input wire logic           sys_rst_i,
    input wire logic [7:0]     reg_addr_i,
    input wire logic [7:0]     reg_wdata_i,
    input wire logic           reg_wr_i,
    input wire logic           reg_rd_i,
    input wire logic [7:0]     reg_rdata_o,
    input wire logic           reg_rvalid_o,
    input wire logic           sar_valid_i,
    input wire logic [3:0]     sar_channel_i,
    input wire logic [11:0]    sar_data_i,
    input wire logic           input_overvoltage_i,
    input wire logic           input_short_battery_i,
    input wire logic           input_diag_any_i,
    input wire logic           overvoltage_fault_o,
    input wire logic           battery_short_fault_o,
    input wire filter_choice_t analog_supply_filter_choice_o,
    input wire filter_choice_t battery_filter_choice_o,
    input wire logic           battery_diag_en_o,
    input wire logic           bias_diag_en_o,
    input wire logic           bias_load_diag_en_o,
    input wire logic           temp_diag_en_o
);
    logic merge_q;
    logic force_q;
    // mirror of stored merge and force bits
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            merge_q <= 1'h0;
            force_q <= 1'h0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `SENSE_FILTER_FAULT_CFG_OFS) merge_q <= reg_wdata_i[`SHORT_MERGE_BIT];
            if (reg_addr_i == `DIAG_ENABLE_CTRL_OFS) force_q <= reg_wdata_i[`FORCE_EN_BIT];
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence bat_load_s;
        sar_valid_i && sar_channel_i == `TAG_BATTERY ##1 !sar_valid_i
            ##1 reg_rd_i && reg_addr_i == `BATTERY_RESULT_HIGH_OFS && !sar_valid_i;
    endsequence
    sequence bias_load_s;
        sar_valid_i && sar_channel_i == `TAG_BIAS ##1 !sar_valid_i
            ##1 reg_rd_i && reg_addr_i == `BIAS_RESULT_LOW_TAG_OFS && !sar_valid_i;
    endsequence
    filt_write_a: assert property (reg_wr_i && reg_addr_i == 8'h54 |=>
        analog_supply_filter_choice_o == $past(reg_wdata_i[6:5]) && battery_filter_choice_o == $past(reg_wdata_i[3:2]))
        else $error("filter field not updated by write");
    separate_fault_a: assert property (!merge_q |=> overvoltage_fault_o == $past(input_overvoltage_i)
        && battery_short_fault_o == $past(input_short_battery_i)) else $error("separate faults wrong");
    merged_fault_a: assert property (merge_q |=> !overvoltage_fault_o
        && battery_short_fault_o == $past(input_overvoltage_i | input_short_battery_i)) else $error("merged fault wrong");
    reserved_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h54 |=>
        reg_rvalid_o && (reg_rdata_o & 8'h92) == 8'h00) else $error("reserved bits not zero");
    battery_upper_a: assert property (bat_load_s |=> reg_rdata_o == $past(sar_data_i[11:4], 3))
        else $error("battery upper byte wrong");
    bias_lower_a: assert property (bias_load_s |=> reg_rdata_o == {$past(sar_data_i[3:0], 3), `TAG_BIAS})
        else $error("bias lower byte wrong");
    auto_enable_a: assert property (!force_q |=> {battery_diag_en_o, bias_diag_en_o, bias_load_diag_en_o,
        temp_diag_en_o} == {4{$past(input_diag_any_i)}}) else $error("auto enable wrong");
endmodule : diag_monitor_checker

bind diag_monitor_registers diag_monitor_checker props_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .sar_valid_i(sar_valid_i),
    .sar_channel_i(sar_channel_i), .sar_data_i(sar_data_i), .input_overvoltage_i(input_overvoltage_i),
    .input_short_battery_i(input_short_battery_i), .input_diag_any_i(input_diag_any_i),
    .overvoltage_fault_o(overvoltage_fault_o), .battery_short_fault_o(battery_short_fault_o),
    .analog_supply_filter_choice_o(analog_supply_filter_choice_o), .battery_diag_en_o(battery_diag_en_o),
    .battery_filter_choice_o(battery_filter_choice_o), .bias_diag_en_o(bias_diag_en_o),
    .bias_load_diag_en_o(bias_load_diag_en_o), .temp_diag_en_o(temp_diag_en_o));

// ---- diag_monitor_registers_tb.sv ----
`timescale 1ns/1ps
module diag_monitor_registers_tb;
    import diag_monitor_pkg::*;
    logic           clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, sv = 1'h0, ov = 1'h0, sh = 1'h0, any = 1'h0;
    logic [7:0]     addr = 8'h00, wdata = 8'h00, d;
    logic [3:0]     ch = 4'h0;
    logic [11:0]    sd = 12'h000;
    logic [15:0]    lf = 16'h0019;
    logic [11:0]    res [3];
    wire logic      rvalid, ovf, bsf;
    wire logic [7:0] rdata;
    wire logic [3:0] en;
    filter_choice_t af, bf;
    int             err_total = 0, check_count = 0, cyc = 0;

    diag_monitor_registers dut (.core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sar_valid_i(sv),
        .sar_channel_i(ch), .sar_data_i(sd), .input_overvoltage_i(ov), .input_short_battery_i(sh),
        .input_diag_any_i(any), .overvoltage_fault_o(ovf), .battery_short_fault_o(bsf),
        .analog_supply_filter_choice_o(af), .battery_filter_choice_o(bf), .battery_diag_en_o(en[3]),
        .bias_diag_en_o(en[2]), .bias_load_diag_en_o(en[1]), .temp_diag_en_o(en[0]));

    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [15:0] nx(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx

    function automatic logic [7:0] exp_res(int k);
        if (k == 5) return 8'h00;
        return k[0] ? {res[k / 2][3:0], 4'(k / 2)} : res[k / 2][11:4];
    endfunction : exp_res

    task automatic chk(string n, logic [11:0] seen, logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(logic [7:0] a, logic [7:0] v);
        @(posedge clk) #1 addr = a;
        wdata = v;
        wr    = 1'h1;
        @(posedge clk) #1 wr = 1'h0;
    endtask : wr_reg

    task automatic rd_chk(logic [7:0] a, logic [7:0] e);
        @(posedge clk) #1 addr = a;
        rd = 1'h1;
        @(posedge clk) #1 rd = 1'h0;
        chk("rvalid", {11'h0, rvalid}, 12'h001);
        chk("rdata", {4'h0, rdata}, {4'h0, e});
    endtask : rd_chk

    task automatic sar(logic [3:0] c, logic [11:0] v);
        @(posedge clk) #1 ch = c;
        sd = v;
        sv = 1'h1;
        @(posedge clk) #1 sv = 1'h0;
    endtask : sar

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        #1 rst = 1'h0;
        chk("filters", {8'h0, af, bf}, 12'h00A);
        rd_chk(8'h54, 8'h48);
        for (int k = 0; k < 5; k++) rd_chk(8'(8'h56 + k), (k == 3) ? 8'h01 : 8'h00);
        for (int i = 0; i < 4; i++) begin
            lf = nx(lf);
            d  = {1'h0, 2'(i), 1'h0, 2'(3 - i), 1'h0, lf[0]};
            wr_reg(8'h54, d);
            rd_chk(8'h54, d & 8'h6D);
            chk("filters", {8'h0, af, bf}, {8'h0, 2'(i), 2'(3 - i)});
        end
        for (int i = 0; i < 16; i++) begin
            if (i % 8 == 0) wr_reg(8'h54, {7'h24, i[3]});
            ov = i[0];
            sh = i[1];
            repeat (2) @(posedge clk);
            #1;
            chk("faults", {10'h0, ovf, bsf}, i[3] ? {11'h0, ov | sh} : {10'h0, ov, sh});
        end
        for (int i = 0; i < 4; i++) begin
            lf = nx(lf);
            sar(4'(i), lf[11:0]);
            if (i < 3) res[i] = lf[11:0];
            if (i < 2) rd_chk(8'(8'h56 + 3 * i), exp_res(3 * i));
        end
        wr_reg(8'h56, 8'hFF);
        for (int k = 0; k < 6; k++) rd_chk(8'(8'h56 + k), exp_res(k));
        any = 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk("auto_en", {8'h0, en}, 12'h00F);
        wr_reg(8'h53, 8'hD1);
        rd_chk(8'h53, 8'hD0);
        chk("forced_en", {8'h0, en}, 12'h00A);
        end_of_test();
    end
endmodule : diag_monitor_registers_tb
